/* logic/bus_mode_pkg.sv */
// Package with mode encodings, register offsets, field positions and reset values.
`default_nettype none
package bus_mode_pkg;
    // Operating modes as sampled from mode_select_hi, mode_select_lo and a test strap.
    typedef enum logic [2:0] {
        MODE_SPECIAL_SINGLE = 3'h0,
        MODE_SPECIAL_NARROW = 3'h1,
        MODE_SPECIAL_TEST   = 3'h2,
        MODE_SPECIAL_WIDE   = 3'h3,
        MODE_NORMAL_SINGLE  = 3'h4,
        MODE_NORMAL_NARROW  = 3'h5,
        MODE_EMULATE_NARROW = 3'h6,
        MODE_NORMAL_WIDE    = 3'h7
    } op_mode_t;

    // Word-aligned byte offsets of the registers.
    localparam logic [3:0] OFS_MODE      = 4'h0;
    localparam logic [3:0] OFS_PORT_E_AS = 4'h4;
    localparam logic [3:0] OFS_BUS_CTRL  = 4'h8;
    localparam logic [3:0] OFS_STATUS    = 4'hC;

    // Mode register fields.
    localparam int MODE_LSB    = 5;
    localparam int MODE_VIS    = 3;
    // Port E assignment fields.
    localparam int PEA_ECLK_DIS = 7;
    localparam int PEA_PIPE     = 5;
    localparam int PEA_LOW_BYTE_STROBE    = 3;
    localparam int PEA_RDW      = 2;
    // Bus interface control fields.
    localparam int BIC_STRETCH  = 0;
    // Status fields.
    localparam int ST_LOCK      = 3;
    localparam int ST_BDM       = 4;

    localparam logic [7:0] PEA_RESET_TEST = 8'h0C;
    localparam logic [7:0] PEA_RESET_EXP  = 8'h2C;
    localparam logic [7:0] PEA_RESET_SGL  = 8'h00;
endpackage : bus_mode_pkg
`default_nettype wire

/* logic/bus_port_mode_setup.sv */
// Mode-dependent reset setup and pin configuration of the external bus interface.
// Contract
// - Normal modes protect controls; special modes open them. Bus control stays writable in every mode.
// - Special single-chip: debug state active after reset.
// - Port E bit 1: input or maskable request.
// - Port E bit 0: input or non-maskable request.
// - Reset sets bus stretch in every mode.
// - Port E bits 6,5 sample mode during reset.
// - Normal single-chip: Ports A, B, E general I/O; here Port E bit 4 still drives the E clock from reset.
// - Port E 1,0 input with pull; others pulled inputs.
// - Normal single-chip: Ports A, B unpulled inputs.
// - Single-chip: no pipe, strobe, read/write functions.
// - Single-chip: those enables reset zero, writes ineffective.
// - Normal single-chip: mode register written once.
// - Port E bit 4 drives E clock when enabled.
// - Port E enables reset per mode; test sets 3:2.
`default_nettype none
module bus_port_mode_setup #(
    parameter int ECLK_DIV = 2
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        test_strap_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  port_e_pin_i,
    output logic      [7:0]  port_e_out_o,
    output logic      [7:0]  port_e_oe_n_o,
    output logic      [7:0]  port_e_pull_o,
    output logic             port_ab_pull_o,
    output logic             port_ab_bus_o,
    output logic             background_debug_state_o,
    output logic             maskable_irq_n_o,
    output logic             nonmaskable_irq_input_n_o,
    input  wire logic        port_e_dir_i,
    input  wire logic [7:0]  port_e_data_i,
    input  wire logic        rw_n_i,
    input  wire logic        low_byte_strobe_n_i,
    input  wire logic [1:0]  pipe_status_i
);
    // Pin synchronisers; the first stage feeds only the second.
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic       strap_meta;
    logic       strap_sync;

    // The synchronisers keep running through reset. Clearing them would hand the mode
    // capture zeros instead of the strap levels at the first edge after release.
    always_ff @(posedge clk_sys_i) begin
        pin_meta   <= port_e_pin_i;
        pin_sync   <= pin_meta;
        strap_meta <= test_strap_i;
        strap_sync <= strap_meta;
    end

    // Mode strap capture: held open while the startup flag is low, frozen after.
    logic                 started;
    bus_mode_pkg::op_mode_t mode;
    // The test strap forces a special mode; without it mode_select_hi high picks a normal one, low a special one.
    wire bus_mode_pkg::op_mode_t strap_mode =
        bus_mode_pkg::op_mode_t'({~strap_sync & pin_sync[6], strap_sync, pin_sync[5]});
    wire strap_single = (strap_mode == bus_mode_pkg::MODE_NORMAL_SINGLE) ||
                        (strap_mode == bus_mode_pkg::MODE_SPECIAL_SINGLE);
    wire strap_test   = (strap_mode == bus_mode_pkg::MODE_SPECIAL_TEST);

    wire is_special = ~mode[2];
    wire is_single  = (mode == bus_mode_pkg::MODE_NORMAL_SINGLE) ||
                      (mode == bus_mode_pkg::MODE_SPECIAL_SINGLE);
    wire is_test    = (mode == bus_mode_pkg::MODE_SPECIAL_TEST);

    // Bus decode.
    wire req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr         = req & wb_we_i & wb_sel_i[0];
    wire wr_mode    = wr & (wb_adr_i == bus_mode_pkg::OFS_MODE);
    wire wr_pea     = wr & (wb_adr_i == bus_mode_pkg::OFS_PORT_E_AS);
    wire wr_bic     = wr & (wb_adr_i == bus_mode_pkg::OFS_BUS_CTRL);

    logic       mode_locked;
    logic [7:0] port_e_assign;
    logic [7:0] bus_interface_control;

    // Normal single-chip allows one mode write; special modes always allow it.
    wire mode_wr_ok = wr_mode & (is_special | ((mode == bus_mode_pkg::MODE_NORMAL_SINGLE) &
                                               ~mode_locked));
    wire [2:0] wr_mode_val = wb_dat_i[bus_mode_pkg::MODE_LSB +: 3];
    // Normal modes may only move into modes with bit 2 set, normal single-chip included.
    wire [2:0] next_mode = is_special ? wr_mode_val : {1'b1, wr_mode_val[1:0]};
    logic       visibility;

    // Reset value of the Port E assignment depends on the mode being sampled, not on
    // the mode register, which still holds its reset value at the capture edge.
    wire [7:0] pea_reset = strap_test   ? bus_mode_pkg::PEA_RESET_TEST :
                           strap_single ? bus_mode_pkg::PEA_RESET_SGL :
                                       bus_mode_pkg::PEA_RESET_EXP;

    // Mode capture and one-time lock. Capture runs in the first cycle after reset release,
    // so the pins are sampled while the reset state is still in force.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            started     <= 1'b0;
            mode        <= bus_mode_pkg::MODE_NORMAL_SINGLE;
            mode_locked <= 1'b0;
            visibility  <= 1'b0;
        end else if (!started) begin
            started <= 1'b1;
            mode    <= strap_mode;
        end else if (mode_wr_ok) begin
            mode        <= bus_mode_pkg::op_mode_t'(next_mode);
            visibility  <= wb_dat_i[bus_mode_pkg::MODE_VIS];
            mode_locked <= 1'b1;
        end
    end

    // Port E assignment and bus control registers.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_e_assign         <= 8'h00;
            bus_interface_control <= 8'h01;
        end else if (!started) begin
            port_e_assign <= pea_reset;
        end else begin
            if (wr_pea && is_special)
                port_e_assign <= wb_dat_i[7:0];
            else if (wr_pea)
                port_e_assign[bus_mode_pkg::PEA_ECLK_DIS] <=
                    wb_dat_i[bus_mode_pkg::PEA_ECLK_DIS];
            if (wr_bic)
                bus_interface_control <= wb_dat_i[7:0];
        end
    end

    // Bus answer: one wait-free cycle, unmapped reads return zero.
    wire [7:0] status_word = {3'h0, background_debug_state_o, mode_locked, mode};
    wire [7:0] rd_mux = (wb_adr_i == bus_mode_pkg::OFS_MODE)      ?
                            {mode, 1'b0, visibility, 3'h0} :
                        (wb_adr_i == bus_mode_pkg::OFS_PORT_E_AS) ? port_e_assign :
                        (wb_adr_i == bus_mode_pkg::OFS_BUS_CTRL)  ? bus_interface_control :
                        (wb_adr_i == bus_mode_pkg::OFS_STATUS)    ? status_word : 8'h00;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // Debug state starts active only in special single-chip mode.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            background_debug_state_o <= 1'b0;
        else if (!started)
            background_debug_state_o <= (strap_mode == bus_mode_pkg::MODE_SPECIAL_SINGLE);
    end

    // E clock divider; a free-running square wave from the system clock.
    logic [7:0] eclk_cnt;
    logic       eclk;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eclk_cnt <= 8'h00;
            eclk     <= 1'b0;
        end else if (eclk_cnt == 8'(ECLK_DIV - 1)) begin
            eclk_cnt <= 8'h00;
            eclk     <= ~eclk;
        end else begin
            eclk_cnt <= eclk_cnt + 8'h01;
        end
    end

    // Pipe, strobe and read/write functions are blocked in single-chip modes whatever the bits say; the E clock is not.
    wire pipe_en  = port_e_assign[bus_mode_pkg::PEA_PIPE]  & ~is_single & started;
    wire low_byte_strobe_en = port_e_assign[bus_mode_pkg::PEA_LOW_BYTE_STROBE] & ~is_single & started;
    wire rdw_en   = port_e_assign[bus_mode_pkg::PEA_RDW]   & ~is_single & started;
    wire eclk_en  = ~port_e_assign[bus_mode_pkg::PEA_ECLK_DIS] & started;

    // Per-pin drive: alternate function, or general output when the port says so.
    wire [7:0] alt_en  = {1'b0, pipe_en, pipe_en, eclk_en, low_byte_strobe_en, rdw_en, 2'b00};
    wire [7:0] alt_val = {1'b0, pipe_status_i, eclk, low_byte_strobe_n_i, rw_n_i, 2'b00};
    // Bits 1:0 are input only; bits 6:5 stay inputs until the mode has been sampled.
    wire [7:0] gp_drive = {port_e_dir_i & started, {2{port_e_dir_i & started}},
                           {3{port_e_dir_i}}, 2'b00};
    wire [7:0] drive   = alt_en | gp_drive;

    assign port_e_out_o  = (alt_en & alt_val) | (~alt_en & port_e_data_i);
    assign port_e_oe_n_o = ~drive;
    // Mode pins 6 and 5 float unpulled while the straps are being sampled.
    assign port_e_pull_o = ~drive & {1'b1, started ? 2'b11 : 2'b00, 5'h1F};
    assign port_ab_bus_o  = ~is_single & started;
    assign port_ab_pull_o = 1'b0;
    assign maskable_irq_n_o         = pin_sync[1];
    assign nonmaskable_irq_input_n_o = pin_sync[0];

    // Checks. Each one watches what the block drives; the bench only steers the inputs.

    // Steps of the one-time mode write: an open write in normal single-chip mode,
    // followed by a locked register that now holds a mode with bit 2 set.
    sequence s_first_mode_wr;
        started && (mode == bus_mode_pkg::MODE_NORMAL_SINGLE) && !mode_locked && wr_mode;
    endsequence

    sequence s_locked_normal;
        mode_locked && mode[2];
    endsequence

    // The reset hand-over: the first edge at which the sampled mode is in force.
    sequence s_mode_taken;
        $rose(started);
    endsequence

    // A locked normal mode ignores later mode writes.
    a_lock_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (mode_locked && !is_special && wr_mode) |=> $stable(mode))
        else $error("mode rewritten");

    // The first normal write is taken and closes the register.
    a_one_write_lock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_first_mode_wr |=> s_locked_normal)
        else $error("mode write not taken");

    // Only reset clears the lock.
    a_lock_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        mode_locked |=> mode_locked)
        else $error("lock dropped");

    // No pipe, strobe or read/write function leaks out in single-chip modes.
    a_single_nostrb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        is_single |-> !low_byte_strobe_en && !rdw_en && !pipe_en)
        else $error("alt fn in single");

    // Bus stretch is set while the mode is taken.
    a_stretch_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !started |-> bus_interface_control[bus_mode_pkg::BIC_STRETCH])
        else $error("stretch");

    // Bus stretch is still set when the sampled mode comes into force.
    a_stretch_taken: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_mode_taken |-> bus_interface_control[bus_mode_pkg::BIC_STRETCH])
        else $error("stretch at start");

    // The debug state is active from the start only in special single-chip mode.
    a_bdm_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_mode_taken |-> background_debug_state_o == (mode == bus_mode_pkg::MODE_SPECIAL_SINGLE))
        else $error("debug state");

    // Request pins are pulled inputs in every mode.
    a_inputs_only: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        port_e_oe_n_o[1:0] == 2'b11 && port_e_pull_o[1:0] == 2'b11)
        else $error("pe1:0");

    // Mode pins float unpulled and undriven until the mode is taken.
    a_mode_pins_hiz: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !started |-> port_e_oe_n_o[6:5] == 2'b11 && port_e_pull_o[6:5] == 2'b00)
        else $error("mode pins");

    // A driven pin never has its pull switched on as well.
    a_pull_undriven: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (port_e_pull_o & ~port_e_oe_n_o) == 8'h00)
        else $error("pull on driven pin");

    // Single-chip pins left as inputs are pulled inputs.
    a_single_pulled: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (started && is_single && !port_e_dir_i) |->
            port_e_oe_n_o[7:5] == 3'b111 && port_e_pull_o[7:5] == 3'b111)
        else $error("single inputs");

    // Single-chip modes keep Ports A and B as unpulled general pins.
    a_single_no_bus: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        is_single |-> !port_ab_bus_o && !port_ab_pull_o)
        else $error("ports a b");

    // Test mode comes up driving the strobe and direction pins.
    a_test_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ($rose(started) && is_test) |-> !port_e_oe_n_o[3] && !port_e_oe_n_o[2])
        else $error("test enables");

    // Single-chip modes come up with the alternate enables cleared.
    a_single_pea: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ($rose(started) && is_single) |-> !port_e_assign[bus_mode_pkg::PEA_PIPE] &&
            !port_e_assign[bus_mode_pkg::PEA_LOW_BYTE_STROBE] && !port_e_assign[bus_mode_pkg::PEA_RDW])
        else $error("single enables");

    // The E clock appears on bit 4 when enabled.
    a_eclk_out: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        eclk_en |-> port_e_out_o[4] == eclk && !port_e_oe_n_o[4])
        else $error("eclk");

    // The E clock keeps toggling at the divider's terminal count.
    a_eclk_toggle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (eclk_cnt == 8'(ECLK_DIV - 1)) |=> $changed(eclk))
        else $error("eclk stuck");

    // Special modes take the whole assignment byte.
    a_pea_special_wr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (started && wr_pea && is_special) |=> port_e_assign == $past(wb_dat_i[7:0]))
        else $error("special write");

    // Normal modes protect all but the clock disable bit.
    a_pea_guard: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (started && wr_pea && !is_special) |=> port_e_assign[6:0] == $past(port_e_assign[6:0]))
        else $error("protected bits");

    // Every taken request is answered in the next cycle.
    a_ack_next: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing");

    // The answer stands one cycle only.
    a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
endmodule : bus_port_mode_setup
`default_nettype wire

/* verif/bus_port_mode_setup_bench.sv */
// Self-checking bench for the Port E and bus mode setup block.
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
    $display("Error at %0t: got %h, expected %h", $time, (a), (e)); end end
module bus_port_mode_setup_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, test_strap_i = 1'b0, v;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic        port_ab_pull_o, port_ab_bus_o, background_debug_state_o;
    logic        maskable_irq_n_o, nonmaskable_irq_input_n_o, port_e_dir_i = 1'b0;
    logic [7:0]  port_e_pin_i, port_e_out_o, port_e_oe_n_o, port_e_pull_o, rd;
    logic [7:0]  port_e_data_i = 8'h00;
    logic        rw_n_i = 1'b0, low_byte_strobe_n_i = 1'b1, hi = 1'b1, lo = 1'b0;
    logic        irq_n = 1'b1, nmi_n = 1'b1;
    logic [1:0]  pipe_status_i = 2'h2;
    int          fails = 0, compares = 0;

    // The clock runs at 25 MHz.
    always #20 clk_sys_i = ~clk_sys_i;

    bus_port_mode_setup #(.ECLK_DIV(2)) dut (
        .clk_sys_i, .rst_n_i, .test_strap_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_e_pin_i,
        .port_e_out_o, .port_e_oe_n_o, .port_e_pull_o, .port_ab_pull_o, .port_ab_bus_o,
        .background_debug_state_o, .maskable_irq_n_o, .nonmaskable_irq_input_n_o,
        .port_e_dir_i, .port_e_data_i, .rw_n_i, .low_byte_strobe_n_i, .pipe_status_i
    );
    port_e_partner ext (
        .clk_i(clk_sys_i), .out_i(port_e_out_o), .oe_n_i(port_e_oe_n_o),
        .pull_i(port_e_pull_o), .mode_hi_i(hi), .mode_lo_i(lo),
        .irq_n_i(irq_n), .nmi_n_i(nmi_n), .pin_o(port_e_pin_i)
    );

    // One classic cycle; the request stands until the edge that sees ack.
    task automatic xfer(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) fails++;
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        `CHK(rd, e)
    endtask : rd_chk

    // Straps are held well before release so the sampled mode is stable.
    task automatic do_reset(input logic h, input logic l, input logic t);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        hi <= h;
        lo <= l;
        test_strap_i <= t;
        repeat (8) @(posedge clk_sys_i);
        `CHK({port_e_oe_n_o[6:5], port_e_pull_o[6:5]}, 4'b1100)
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask : do_reset

    task automatic normal_single;
        rd_chk(bus_mode_pkg::OFS_BUS_CTRL, 8'h01);
        rd_chk(bus_mode_pkg::OFS_PORT_E_AS, 8'h00);
        rd_chk(bus_mode_pkg::OFS_STATUS, 8'h04);
        rd_chk(4'h2, 8'h00);
        `CHK({port_ab_bus_o, port_ab_pull_o}, 2'b00)
        `CHK({port_e_oe_n_o[6:5], port_e_oe_n_o[3:0]}, 6'h3F)
        `CHK({port_e_pull_o[6:5], port_e_pull_o[3:0]}, 6'h3F)
        @(negedge clk_sys_i);
        v = port_e_out_o[4];
        `CHK(port_e_oe_n_o[4], 1'b0)
        repeat (2) @(negedge clk_sys_i);
        `CHK(port_e_out_o[4], ~v)
        @(posedge clk_sys_i);
        irq_n <= 1'b0;
        port_e_dir_i <= 1'b1;
        port_e_data_i <= 8'h80;
        repeat (4) @(posedge clk_sys_i);
        `CHK({maskable_irq_n_o, nonmaskable_irq_input_n_o}, 2'b01)
        `CHK({port_e_oe_n_o[7], port_e_out_o[7]}, 2'b01)
        irq_n <= 1'b1;
        nmi_n <= 1'b0;
        port_e_dir_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        `CHK({maskable_irq_n_o, nonmaskable_irq_input_n_o}, 2'b10)
        nmi_n <= 1'b1;
        // Normal mode lets software touch only the clock disable bit.
        xfer(1'b1, bus_mode_pkg::OFS_PORT_E_AS, 8'hAC);
        rd_chk(bus_mode_pkg::OFS_PORT_E_AS, 8'h80);
        `CHK(port_e_oe_n_o[4:2], 3'b111)
        xfer(1'b1, bus_mode_pkg::OFS_MODE, 8'hE8);
        rd_chk(bus_mode_pkg::OFS_STATUS, 8'h0F);
        `CHK(port_ab_bus_o, 1'b1)
        xfer(1'b1, bus_mode_pkg::OFS_MODE, 8'hA0);
        rd_chk(bus_mode_pkg::OFS_STATUS, 8'h0F);
    endtask : normal_single

    task automatic special_modes;
        do_reset(1'b1, 1'b0, 1'b1);
        rd_chk(bus_mode_pkg::OFS_PORT_E_AS, 8'h0C);
        rd_chk(bus_mode_pkg::OFS_BUS_CTRL, 8'h01);
        `CHK({port_e_oe_n_o[3:2], port_e_pull_o[3:2]}, 4'h0)
        `CHK(port_e_out_o[3:2], 2'b10)
        // Outside single-chip modes the pipe status does reach pins 6 and 5.
        xfer(1'b1, bus_mode_pkg::OFS_PORT_E_AS, 8'h2C);
        `CHK({port_e_oe_n_o[6:5], port_e_out_o[6:5]}, 4'b0010)
        do_reset(1'b0, 1'b0, 1'b0);
        `CHK(background_debug_state_o, 1'b1)
        rd_chk(bus_mode_pkg::OFS_STATUS, 8'h10);
        xfer(1'b1, bus_mode_pkg::OFS_PORT_E_AS, 8'h2C);
        rd_chk(bus_mode_pkg::OFS_PORT_E_AS, 8'h2C);
        `CHK({port_e_oe_n_o[6:5], port_e_oe_n_o[3:2]}, 4'hF)
    endtask : special_modes

    task automatic finish_test;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Main sequence, run after the initial reset.
    initial begin
        do_reset(1'b1, 1'b0, 1'b0);
        normal_single();
        special_modes();
        finish_test();
    end

    // The whole run needs well under 2000 cycles.
    initial begin
        #200000;
        fails++;
        finish_test();
    end
endmodule : bus_port_mode_setup_bench
`default_nettype wire

/* verif/port_e_partner.sv */
// Model of the straps and request lines wired to Port E outside the block.
`default_nettype none
module port_e_partner (
    input  wire logic       clk_i,
    input  wire logic [7:0] out_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pull_i,
    input  wire logic       mode_hi_i,
    input  wire logic       mode_lo_i,
    input  wire logic       irq_n_i,
    input  wire logic       nmi_n_i,
    output logic      [7:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       flip = 1'b0;
    logic [7:0] ext;
    // A floating pin without pull toggles, so a stale level cannot pass for a driven one.
    always_ff @(posedge clk_i) begin
        flip <= ~flip;
    end
    // Straps sit on bits 6 and 5, the request lines on bits 1 and 0.
    assign ext = {pull_i[7] | flip, mode_hi_i, mode_lo_i, pull_i[4:2] | {3{flip}},
                  irq_n_i, nmi_n_i};
    // The debug host is not modelled: it only talks to the core, never to these pins.
    // A pin that the block drives shows the block's value.
    assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext);
endmodule : port_e_partner
`default_nettype wire
